// File: rtl/reset_cause_pkg.sv
// package: constants and types of the reset cause and enable register
`default_nettype none

package reset_cause_pkg;

	// register address in the special-function space
	localparam logic [7:0] RESET_CAUSE_ADDR = 8'hEF;

	// bit positions inside the register
	localparam int FLASH_BIT = 6;
	localparam int CMP_BIT   = 5;
	localparam int SW_BIT    = 4;
	localparam int WDT_BIT   = 3;
	localparam int MCD_BIT   = 2;
	localparam int POR_BIT   = 1;
	localparam int PIN_BIT   = 0;
	localparam int FLAG_N    = 7;

	// values after power-on reset
	localparam logic             MCD_EN_RESET = 1'b0;
	localparam logic             CMP_EN_RESET = 1'b0;
	localparam logic             VDD_EN_RESET = 1'b1;
	localparam logic [FLAG_N-1:0] FLAGS_RESET = 7'h02;
	localparam logic [7:0]       RDATA_RESET  = 8'h00;

	// system reset hold time after the last request goes away
	localparam int CLK_MHZ     = 200;
	localparam int HOLD_NS     = 100;
	localparam int HOLD_CYCLES = (HOLD_NS * CLK_MHZ + 999) / 1000;
	localparam int HOLD_W      = 5;
	localparam logic [HOLD_W-1:0] HOLD_LOAD = HOLD_W'(HOLD_CYCLES - 1);
	localparam logic [HOLD_W-1:0] HOLD_ZERO = 5'h00;

	// reset causes, highest priority first after none
	typedef enum logic [2:0] {
		CAUSE_NONE,
		CAUSE_POWER,
		CAUSE_PIN,
		CAUSE_CLOCK_LOSS,
		CAUSE_COMPARATOR,
		CAUSE_WATCHDOG,
		CAUSE_FLASH,
		CAUSE_SOFTWARE
	} cause_t;

	// cause reported by each flag bit, index is the bit position
	localparam cause_t FLAG_CAUSE [0:FLAG_N-1] = '{
		CAUSE_PIN, CAUSE_POWER, CAUSE_CLOCK_LOSS, CAUSE_WATCHDOG,
		CAUSE_SOFTWARE, CAUSE_COMPARATOR, CAUSE_FLASH
	};

	// system reset sequencer states
	typedef enum logic {
		ST_RUN,
		ST_HOLD
	} seq_state_t;

endpackage : reset_cause_pkg

`default_nettype wire

// File: rtl/reset_cause_register.sv
// module: reset cause capture, reset source enables and software reset
`default_nettype none

// Notes on behaviour
// - bit 6 is read-only, set when a flash access error caused the last reset
// - writing 1 to bit 5 arms the comparator reset, active while output low
// - bit 5 reads 1 only after a comparator-caused reset
// - writing 1 to bit 4 starts a system reset at once
// - bit 4 reads 1 only after a software-forced reset
// - bit 3 is read-only, set when watchdog overflow caused the last reset
// - writing 1 to bit 2 arms clock loss detection; bit 2 flags its reset
// - bit 1 write arms the supply monitor reset; write only once monitor settled
// - bit 1 reads 1 after every power-on or supply monitor reset
// - while bit 1 is set the other cause flags carry no meaning
// - bit 0 is read-only, set when the external reset pin caused the last reset
// - writing 0 to bit 2 disarms clock loss detection
// - supply monitor reset armed after power-on, kept through other resets
// - internal resets never drive or change the external reset pin

module reset_cause_register (
	// clock, reset and clock enable
	input  wire logic        CORE_CLK,
	input  wire logic        RST_N,
	input  wire logic        CE,
	// special-function register port
	input  wire logic [7:0]  SFR_ADDR,
	input  wire logic        SFR_WR,
	input  wire logic        SFR_RD,
	input  wire logic [7:0]  SFR_WDATA,
	output logic      [7:0]  SFR_RDATA,
	// reset sources
	input  wire logic        PIN_RST_N,
	input  wire logic        VDD_LOW,
	input  wire logic        MCD_TIMEOUT,
	input  wire logic        CMP_OUT,
	input  wire logic        WDT_OVF,
	input  wire logic        FLASH_ERR,
	// system reset and source arming
	output logic             SYS_RST_N,
	output logic             MCD_EN,
	output logic             CMP_RST_EN,
	output logic             VDD_RST_EN
);
	import reset_cause_pkg::*;

	// synchronised reset
	logic [1:0]              rst_sync_q;
	logic                    rst_n;

	// sequencer
	seq_state_t              state_q;
	seq_state_t              state_d;
	logic [HOLD_W-1:0]       hold_cnt_q;
	cause_t                  cause_q;
	logic                    hold_done;
	logic                    enter_hold;
	logic                    in_run;
	logic                    in_hold;
	logic                    power_entry;

	// register contents
	logic [FLAG_N-1:0]       flags_q;
	logic [FLAG_N-1:0]       flags_d;
	logic                    mcd_en_q;
	logic                    cmp_en_q;
	logic                    vdd_en_q;
	logic                    sys_rst_n_q;
	logic [7:0]              rdata_q;

	// next values
	logic [HOLD_W-1:0]       hold_cnt_d;
	cause_t                  cause_d;
	logic                    sys_rst_n_d;
	logic [7:0]              rdata_d;

	// bus decode
	logic                    addr_hit;
	logic                    wr_hit;

	// gated requests
	logic                    req_power;
	logic                    req_pin;
	logic                    req_clock_loss;
	logic                    req_comparator;
	logic                    req_watchdog;
	logic                    req_flash;
	logic                    req_software;
	logic                    any_req;
	cause_t                  sel_cause;
	logic                    level_req;

	// reset release through two flops, assertion stays asynchronous
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			rst_sync_q <= 2'b00;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end

	assign rst_n = rst_sync_q[1];

	// state decode shared by the bus and the sequencer
	assign in_run  = (state_q == ST_RUN);
	assign in_hold = (state_q == ST_HOLD);

	// register decode; writes are ignored while the system is held in reset
	assign addr_hit = (SFR_ADDR == RESET_CAUSE_ADDR);
	assign wr_hit   = SFR_WR & addr_hit & in_run;

	// written bits 5, 4, 2 and 1 act as commands, so write-back of flags would fire them
	// a written 1 in bit 4 is itself the request, no extra cycle
	assign req_software   = wr_hit & SFR_WDATA[SW_BIT];
	assign req_comparator = cmp_en_q & ~CMP_OUT;
	assign req_clock_loss = mcd_en_q & MCD_TIMEOUT;
	assign req_power      = vdd_en_q & VDD_LOW;
	// pin, watchdog and flash have no arming bit and always act
	assign req_pin        = ~PIN_RST_N;
	assign req_watchdog   = WDT_OVF;
	assign req_flash      = FLASH_ERR;

	// level sources keep the system in reset as long as they stay active
	assign level_req = req_pin | req_power;

	// pick the single cause to report
	reset_cause_select u_select (
		.req_power      (req_power),
		.req_pin        (req_pin),
		.req_clock_loss (req_clock_loss),
		.req_comparator (req_comparator),
		.req_watchdog   (req_watchdog),
		.req_flash      (req_flash),
		.req_software   (req_software),
		.any_req        (any_req),
		.cause          (sel_cause)
	);

	// sequencer next state
	assign hold_done   = (hold_cnt_q == HOLD_ZERO) & ~level_req;
	assign enter_hold  = in_run & any_req;
	assign power_entry = enter_hold & (sel_cause == CAUSE_POWER);

	always_comb begin
		case (state_q)
			ST_RUN: begin
				state_d = any_req ? ST_HOLD : ST_RUN;
			end
			ST_HOLD: begin
				state_d = hold_done ? ST_RUN : ST_HOLD;
			end
			default: begin
				state_d = ST_HOLD;
			end
		endcase
	end

	// state register, power-on starts in the hold state
	always_ff @(posedge CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ST_HOLD;
		end else if (CE) begin
			state_q <= state_d;
		end
	end

	// hold counter next value, reloaded while a level source is still asserted
	// the reload makes the hold outlast the last active cycle of pin or supply
	always_comb begin
		hold_cnt_d = hold_cnt_q;
		if (enter_hold || (in_hold && level_req)) begin
			hold_cnt_d = HOLD_LOAD;
		end else if (in_hold && (hold_cnt_q != HOLD_ZERO)) begin
			hold_cnt_d = hold_cnt_q - 5'h01;
		end
	end

	// hold counter register
	always_ff @(posedge CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			hold_cnt_q <= HOLD_LOAD;
		end else if (CE) begin
			hold_cnt_q <= hold_cnt_d;
		end
	end

	// pending cause; a supply dip during a hold turns it into a power reset
	// pulse sources arriving during a hold leave the pending cause alone
	always_comb begin
		cause_d = cause_q;
		if (enter_hold) begin
			cause_d = sel_cause;
		end else if (in_hold && req_power) begin
			cause_d = CAUSE_POWER;
		end
	end

	// pending cause register, power is the cause after power-on
	always_ff @(posedge CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			cause_q <= CAUSE_POWER;
		end else if (CE) begin
			cause_q <= cause_d;
		end
	end

	// decode the pending cause into one flag per bit
	for (genvar i = 0; i < FLAG_N; i++) begin : g_flag
		assign flags_d[i] = (cause_q == FLAG_CAUSE[i]);
	end

	// flags change only as the hold ends, then stay until the next reset
	// after a power reset the other flags are cleared, software ignores them
	always_ff @(posedge CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			flags_q <= FLAGS_RESET;
		end else if (CE) begin
			if (in_hold && hold_done) begin
				flags_q <= flags_d;
			end
		end
	end

	// clock loss arming: write 1 arms, write 0 disarms, any reset disarms
	always_ff @(posedge CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			mcd_en_q <= MCD_EN_RESET;
		end else if (CE) begin
			if (enter_hold) begin
				mcd_en_q <= MCD_EN_RESET;
			end else if (wr_hit) begin
				mcd_en_q <= SFR_WDATA[MCD_BIT];
			end
		end
	end

	// comparator arming, dropped by any system reset
	always_ff @(posedge CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			cmp_en_q <= CMP_EN_RESET;
		end else if (CE) begin
			if (enter_hold) begin
				cmp_en_q <= CMP_EN_RESET;
			end else if (wr_hit) begin
				cmp_en_q <= SFR_WDATA[CMP_BIT];
			end
		end
	end

	// supply monitor arming: on after power reset, untouched by other resets
	always_ff @(posedge CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			vdd_en_q <= VDD_EN_RESET;
		end else if (CE) begin
			if (power_entry) begin
				vdd_en_q <= VDD_EN_RESET;
			end else if (wr_hit) begin
				vdd_en_q <= SFR_WDATA[POR_BIT];
			end
		end
	end

	// system reset follows the next state, so it drops on the request edge
	assign sys_rst_n_d = (state_d == ST_RUN);

	// system reset output, low for the whole hold; no path reaches the pin
	always_ff @(posedge CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			sys_rst_n_q <= 1'b0;
		end else if (CE) begin
			sys_rst_n_q <= sys_rst_n_d;
		end
	end

	// read data next value, unmapped addresses read zero, top bit always zero
	// reads are served during a hold as well, only writes are refused there
	always_comb begin
		rdata_d = rdata_q;
		if (SFR_RD && addr_hit) begin
			rdata_d = {1'b0, flags_q};
		end else if (SFR_RD) begin
			rdata_d = RDATA_RESET;
		end
	end

	// read data register, holds its value between reads
	always_ff @(posedge CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			rdata_q <= RDATA_RESET;
		end else if (CE) begin
			rdata_q <= rdata_d;
		end
	end

	// outputs straight from flops
	assign SFR_RDATA  = rdata_q;
	assign SYS_RST_N  = sys_rst_n_q;
	assign MCD_EN     = mcd_en_q;
	assign CMP_RST_EN = cmp_en_q;
	assign VDD_RST_EN = vdd_en_q;

endmodule // reset_cause_register

`default_nettype wire

// File: rtl/reset_cause_select.sv
// module: priority selection among pending system reset requests
`default_nettype none

module reset_cause_select (
	// requests, already gated by their enables
	input  wire logic                    req_power,
	input  wire logic                    req_pin,
	input  wire logic                    req_clock_loss,
	input  wire logic                    req_comparator,
	input  wire logic                    req_watchdog,
	input  wire logic                    req_flash,
	input  wire logic                    req_software,
	// result
	output logic                         any_req,
	output reset_cause_pkg::cause_t      cause
);
	import reset_cause_pkg::*;

	// one cause wins so exactly one flag is recorded
	always_comb begin
		any_req = 1'b1;
		if (req_power) begin
			cause = CAUSE_POWER;
		end else if (req_pin) begin
			cause = CAUSE_PIN;
		end else if (req_clock_loss) begin
			cause = CAUSE_CLOCK_LOSS;
		end else if (req_comparator) begin
			cause = CAUSE_COMPARATOR;
		end else if (req_watchdog) begin
			cause = CAUSE_WATCHDOG;
		end else if (req_flash) begin
			cause = CAUSE_FLASH;
		end else if (req_software) begin
			cause = CAUSE_SOFTWARE;
		end else begin
			cause   = CAUSE_NONE;
			any_req = 1'b0;
		end
	end

endmodule // reset_cause_select

`default_nettype wire

// File: verif/reset_cause_register_props.sv
// checker: port-level properties of the reset cause register
`default_nettype none

module reset_cause_register_props
	import reset_cause_pkg::*;
(
	// clock, reset, enable
	input wire logic       CORE_CLK,
	input wire logic       RST_N,
	input wire logic       CE,
	// register port
	input wire logic [7:0] SFR_ADDR,
	input wire logic       SFR_WR,
	input wire logic       SFR_RD,
	input wire logic [7:0] SFR_WDATA,
	input wire logic [7:0] SFR_RDATA,
	// reset sources
	input wire logic       PIN_RST_N,
	input wire logic       VDD_LOW,
	input wire logic       MCD_TIMEOUT,
	input wire logic       CMP_OUT,
	input wire logic       WDT_OVF,
	input wire logic       FLASH_ERR,
	// outputs
	input wire logic       SYS_RST_N,
	input wire logic       MCD_EN,
	input wire logic       CMP_RST_EN,
	input wire logic       VDD_RST_EN
);
	timeunit 1ns;
	timeprecision 1ps;

	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!RST_N);

	logic       run, wr, quiet;
	logic [7:0] low_q;

	// accepted write and absence of any other request
	assign run = SYS_RST_N && CE;
	assign wr = run && SFR_WR && SFR_ADDR == RESET_CAUSE_ADDR;
	assign quiet = PIN_RST_N && !WDT_OVF && !FLASH_ERR && !(VDD_LOW && VDD_RST_EN)
		&& !(MCD_EN && MCD_TIMEOUT) && !(CMP_RST_EN && !CMP_OUT);

	// cycles spent in system reset
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N)
			low_q <= 8'h00;
		else if (SYS_RST_N)
			low_q <= 8'h00;
		else if (low_q != 8'hFF)
			low_q <= low_q + 8'h01;
	end

	a_sw_reset_force:
		assert property (wr && SFR_WDATA[4] |=> !SYS_RST_N && !MCD_EN && !CMP_RST_EN)
		else $error("software reset missing");
	a_mcd_arm_write:
		assert property (wr && quiet && !SFR_WDATA[4] |=> MCD_EN == $past(SFR_WDATA[2]))
		else $error("clock loss arming wrong");
	a_cmp_arm_write:
		assert property (wr && quiet && !SFR_WDATA[4] |=> CMP_RST_EN == $past(SFR_WDATA[5]))
		else $error("comparator arming wrong");
	a_idle_no_reset:
		assert property (run && quiet && !wr |=> SYS_RST_N)
		else $error("reset without armed cause");
	a_cmp_reset_entry:
		assert property (run && CMP_RST_EN && !CMP_OUT |=> !SYS_RST_N && !CMP_RST_EN)
		else $error("comparator reset missing");
	a_wdt_reset_hold:
		assert property (run && WDT_OVF |=> !SYS_RST_N [*8])
		else $error("watchdog reset missing");
	a_pin_reset_hold:
		assert property (CE && !PIN_RST_N |=> !SYS_RST_N [*8])
		else $error("pin reset missing");
	a_supply_arm_kept:
		assert property (!SYS_RST_N && !VDD_LOW |=> VDD_RST_EN == $past(VDD_RST_EN))
		else $error("supply arming changed in reset");
	a_power_reset_entry:
		assert property (run && VDD_LOW && VDD_RST_EN |=> !SYS_RST_N && VDD_RST_EN)
		else $error("supply reset missing");
	a_hold_min_len:
		assert property ($rose(SYS_RST_N) |-> low_q >= 8'(HOLD_CYCLES))
		else $error("reset hold too short");

	// main scenarios reached
	c_sw: cover property (wr && SFR_WDATA[4]);
	c_wdt: cover property (run && WDT_OVF);
	c_leave: cover property ($rose(SYS_RST_N));
endmodule // reset_cause_register_props

`default_nettype wire

// File: verif/tb_top.sv
// testbench: reset cause register against a cause model
`default_nettype none

module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import reset_cause_pkg::*;

	logic        CORE_CLK = 1'b0, RST_N = 1'b0, CE = 1'b1;
	logic [7:0]  SFR_ADDR = 8'h00, SFR_WDATA = 8'h00, SFR_RDATA;
	logic        SFR_WR = 1'b0, SFR_RD = 1'b0, PIN_RST_N = 1'b1, VDD_LOW = 1'b0;
	logic        MCD_TIMEOUT = 1'b0, CMP_OUT = 1'b1, WDT_OVF = 1'b0, FLASH_ERR = 1'b0;
	logic        SYS_RST_N, MCD_EN, CMP_RST_EN, VDD_RST_EN, ven;
	logic [7:0]  rd;
	logic [31:0] rs = 32'd40;
	int          num_errors = 0, check_count = 0, cyc = 0, n;
	// cause model: causes in order, arming as {clock loss, comparator, supply}
	int          m_arm = 1;
	int          m_cause_q[$];

	reset_cause_register dut (
		.CORE_CLK   (CORE_CLK),
		.RST_N      (RST_N),
		.CE         (CE),
		.SFR_ADDR   (SFR_ADDR),
		.SFR_WR     (SFR_WR),
		.SFR_RD     (SFR_RD),
		.SFR_WDATA  (SFR_WDATA),
		.SFR_RDATA  (SFR_RDATA),
		.PIN_RST_N  (PIN_RST_N),
		.VDD_LOW    (VDD_LOW),
		.MCD_TIMEOUT(MCD_TIMEOUT),
		.CMP_OUT    (CMP_OUT),
		.WDT_OVF    (WDT_OVF),
		.FLASH_ERR  (FLASH_ERR),
		.SYS_RST_N  (SYS_RST_N),
		.MCD_EN     (MCD_EN),
		.CMP_RST_EN (CMP_RST_EN),
		.VDD_RST_EN (VDD_RST_EN)
	);

	// 200 MHz clock and run ceiling
	always #2.5 CORE_CLK = ~CORE_CLK;
	always @(posedge CORE_CLK) begin
		cyc++;
		if (cyc == 3000) begin
			num_errors++;
			close_out();
		end
	end

	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction

	// compare one value against the model
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		check_count++;
		if (g !== e) begin
			num_errors++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask

	// register write and read, one idle cycle then one strobe cycle each
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge CORE_CLK);
		SFR_ADDR = a;
		SFR_WDATA = d;
		SFR_WR = 1'b1;
		if (a == RESET_CAUSE_ADDR && CE) begin
			if (d[SW_BIT])
				m_cause_q.push_back(SW_BIT);
			m_arm = d[SW_BIT] ? int'(d[POR_BIT]) : int'({d[MCD_BIT], d[CMP_BIT], d[POR_BIT]});
		end
		@(negedge CORE_CLK);
		SFR_WR = 1'b0;
	endtask
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		@(negedge CORE_CLK);
		SFR_ADDR = a;
		SFR_RD = 1'b1;
		@(negedge CORE_CLK);
		SFR_RD = 1'b0;
		d = SFR_RDATA;
	endtask

	// arming outputs expected after a write or reset
	task automatic arm(input logic [2:0] e);
		chk("arming", {5'h00, e}, {5'h00, MCD_EN, CMP_RST_EN, VDD_RST_EN});
		chk("model arming", 8'(m_arm), {5'h00, MCD_EN, CMP_RST_EN, VDD_RST_EN});
	endtask

	// one-cycle cause k, then hold length, flag and arming
	task automatic hit(input int k);
		if (k == SW_BIT)
			wr(RESET_CAUSE_ADDR, 8'h10);
		else begin
			PIN_RST_N = (k != PIN_BIT);
			VDD_LOW = (k == POR_BIT);
			MCD_TIMEOUT = (k == MCD_BIT);
			CMP_OUT = (k != CMP_BIT);
			WDT_OVF = (k == WDT_BIT);
			FLASH_ERR = (k == FLASH_BIT);
			m_cause_q.push_back(k);
			m_arm = (k == POR_BIT) ? 1 : (m_arm & 1);
			@(negedge CORE_CLK);
			{PIN_RST_N, VDD_LOW, MCD_TIMEOUT, CMP_OUT, WDT_OVF, FLASH_ERR} = 6'h24;
		end
		n = 0;
		while (SYS_RST_N === 1'b0 && n < 40) begin
			@(negedge CORE_CLK);
			n++;
		end
		chk("hold", 8'(HOLD_CYCLES), 8'(n));
		rd_reg(RESET_CAUSE_ADDR, rd);
		chk("flags", 8'(1 << m_cause_q.pop_front()), rd);
		arm({2'b00, ven});
	endtask

	task automatic close_out();
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// main sequence
	initial begin
		ven = 1'b1;
		repeat (5) @(negedge CORE_CLK);
		RST_N = 1'b1;
		n = 0;
		while (SYS_RST_N !== 1'b1 && n < 40) begin
			@(negedge CORE_CLK);
			n++;
		end
		rd_reg(RESET_CAUSE_ADDR, rd);
		chk("power flags", 8'h02, rd);
		arm(3'b001);
		rs = xs(rs);
		rd_reg((rs[7:0] == 8'hEF) ? 8'h00 : rs[7:0], rd);
		chk("unmapped", 8'h00, rd);
		rs = xs(rs);
		wr(RESET_CAUSE_ADDR, rs[7:0] & 8'hC9);
		rd_reg(RESET_CAUSE_ADDR, rd);
		chk("read only", 8'h02, rd);
		ven = 1'b0;
		MCD_TIMEOUT = 1'b1;
		CMP_OUT = 1'b0;
		@(negedge CORE_CLK);
		MCD_TIMEOUT = 1'b0;
		CMP_OUT = 1'b1;
		chk("no reset", 8'h01, {7'h00, SYS_RST_N});
		wr(RESET_CAUSE_ADDR, 8'h04);
		arm(3'b100);
		wr(RESET_CAUSE_ADDR, 8'h00);
		arm(3'b000);
		CE = 1'b0;
		wr(RESET_CAUSE_ADDR, 8'h24);
		arm(3'b000);
		CE = 1'b1;
		wr(RESET_CAUSE_ADDR, 8'h24);
		arm(3'b110);
		hit(MCD_BIT);
		wr(RESET_CAUSE_ADDR, 8'h20);
		hit(CMP_BIT);
		hit(WDT_BIT);
		hit(FLASH_BIT);
		hit(SW_BIT);
		hit(PIN_BIT);
		wr(RESET_CAUSE_ADDR, 8'h02);
		ven = 1'b1;
		hit(POR_BIT);
		close_out();
	end
endmodule // tb_top

bind reset_cause_register reset_cause_register_props u_props (
	.CORE_CLK   (CORE_CLK),
	.RST_N      (RST_N),
	.CE         (CE),
	.SFR_ADDR   (SFR_ADDR),
	.SFR_WR     (SFR_WR),
	.SFR_RD     (SFR_RD),
	.SFR_WDATA  (SFR_WDATA),
	.SFR_RDATA  (SFR_RDATA),
	.PIN_RST_N  (PIN_RST_N),
	.VDD_LOW    (VDD_LOW),
	.MCD_TIMEOUT(MCD_TIMEOUT),
	.CMP_OUT    (CMP_OUT),
	.WDT_OVF    (WDT_OVF),
	.FLASH_ERR  (FLASH_ERR),
	.SYS_RST_N  (SYS_RST_N),
	.MCD_EN     (MCD_EN),
	.CMP_RST_EN (CMP_RST_EN),
	.VDD_RST_EN (VDD_RST_EN)
);

`default_nettype wire
